/* rtl/lsd_pkg.sv */
// Shared constants and carriers for the low-side predriver supervisor
`default_nettype none
package lsd_pkg;
  localparam int NCH = 4;
  localparam int CLK_HZ = 20000000;
  // Times in their own units
  localparam int MASK_US       = 60;
  localparam int DEGLITCH_US   = 8;
  localparam int RETRY_PER_MS  = 10;
  localparam int RETRY_PW_US   = 68;
  // Cycle counts derived from the clock rate
  localparam int MASK_CYC      = MASK_US * (CLK_HZ / 1000000);
  localparam int DEGLITCH_CYC  = DEGLITCH_US * (CLK_HZ / 1000000);
  localparam int RETRY_PER_CYC = RETRY_PER_MS * (CLK_HZ / 1000);
  localparam int RETRY_PW_CYC  = RETRY_PW_US * (CLK_HZ / 1000000);
  localparam int CNT_W = 18;
  // Reset values
  localparam logic [NCH-1:0] CTRL_RST  = 4'h0;
  localparam logic [NCH-1:0] FAULT_RST = 4'h0;

  // Per-channel supervisor states
  typedef enum logic [2:0] {
    CH_OFF_MASK = 3'b000,
    CH_OFF_CHK  = 3'b001,
    CH_ON_MASK  = 3'b010,
    CH_ON_CHK   = 3'b011,
    CH_SHUT     = 3'b100,
    CH_RETRY    = 3'b101
  } ch_state_e;

  // Analog indications after synchronising
  typedef struct packed {
    logic over_bat;
    logic under_bat;
    logic [NCH-1:0] drain_high;
  } sense_s;

  // Serial control side, already edge-detected
  typedef struct packed {
    logic cs_fall;
    logic cs_rise;
    logic [NCH-1:0] shifted_ctrl;
  } serial_evt_s;

  function automatic logic [CNT_W-1:0] cnt_inc(input logic [CNT_W-1:0] c);
    cnt_inc = c + 18'h00001;
  endfunction
endpackage
`default_nettype wire

/* rtl/lsd_sync.sv */
// Two-flop synchroniser for a bus of asynchronous inputs
`default_nettype none
module lsd_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  // Data
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta_r;
  logic [W-1:0] meta_nxt;
  logic [W-1:0] q_r;
  logic [W-1:0] q_nxt;

  // Only the second stage is visible outside
  always_comb begin
    meta_nxt = d_i;
    q_nxt    = meta_r;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      meta_r <= '0;
      q_r    <= '0;
    end else begin
      meta_r <= meta_nxt;
      q_r    <= q_nxt;
    end
  end

  assign q_o = q_r;
endmodule
`default_nettype wire

/* rtl/lsd_channel.sv */
// One channel: mask, deglitch, shorted-load and open-load supervision
`default_nettype none
module lsd_channel
  import lsd_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  // Control
  input  wire logic cmd_on_i,
  input  wire logic bat_fault_i,
  input  wire logic retry_mode_i,
  input  wire logic drain_high_i,
  // Results
  output logic      gate_o,
  output logic      short_o,
  output logic      open_o
);
  import lsd_pkg::*;

  ch_state_e        st_r;
  ch_state_e        st_nxt;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] dg_r;
  logic [CNT_W-1:0] dg_nxt;
  logic             gate_r;
  logic             gate_nxt;
  logic             on_req;

  // Battery lockout forces every gate off
  assign on_req = cmd_on_i & ~bat_fault_i;

  // Supervisor state machine
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_inc(cnt_r);
    dg_nxt   = '0;
    gate_nxt = gate_r;
    case (st_r)
      CH_OFF_MASK: begin
        gate_nxt = 1'b0;
        if (on_req) begin
          st_nxt = CH_ON_MASK;
          cnt_nxt = '0;
          gate_nxt = 1'b1;
        end else if (cnt_r >= CNT_W'(MASK_CYC - 1)) begin
          st_nxt = CH_OFF_CHK;
        end
      end
      CH_OFF_CHK: begin
        gate_nxt = 1'b0;
        if (on_req) begin
          st_nxt = CH_ON_MASK;
          cnt_nxt = '0;
          gate_nxt = 1'b1;
        end
      end
      CH_ON_MASK: begin
        if (!on_req) begin
          st_nxt = CH_OFF_MASK;
          cnt_nxt = '0;
          gate_nxt = 1'b0;
        end else if (cnt_r >= CNT_W'(MASK_CYC - 1)) begin
          st_nxt = CH_ON_CHK;
        end
      end
      CH_ON_CHK: begin
        if (!on_req) begin
          st_nxt = CH_OFF_MASK;
          cnt_nxt = '0;
          gate_nxt = 1'b0;
        end else if (drain_high_i) begin
          // Drain must stay high for the whole deglitch span
          dg_nxt = cnt_inc(dg_r);
          if (dg_r >= CNT_W'(DEGLITCH_CYC - 1)) begin
            st_nxt   = retry_mode_i ? CH_RETRY : CH_SHUT;
            cnt_nxt  = '0;
            gate_nxt = 1'b0;
          end
        end
      end
      CH_SHUT: begin
        // Held off until commanded off, then on again
        gate_nxt = 1'b0;
        if (!cmd_on_i) begin
          st_nxt = CH_OFF_MASK;
          cnt_nxt = '0;
        end
      end
      CH_RETRY: begin
        // Low-duty pulse train; a clean pulse ends the fault
        if (!on_req) begin
          st_nxt = CH_OFF_MASK;
          cnt_nxt = '0;
          gate_nxt = 1'b0;
        end else begin
          if (cnt_r >= CNT_W'(RETRY_PER_CYC - 1)) cnt_nxt = '0;
          gate_nxt = (cnt_nxt < CNT_W'(RETRY_PW_CYC));
          if (gate_r && !drain_high_i && cnt_r == CNT_W'(RETRY_PW_CYC - 1)) begin
            st_nxt = CH_ON_CHK;
            gate_nxt = 1'b1;
          end
        end
      end
      default: begin
        st_nxt = CH_OFF_MASK;
        gate_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_r   <= CH_OFF_MASK;
      cnt_r  <= '0;
      dg_r   <= '0;
      gate_r <= 1'b0;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      dg_r   <= dg_nxt;
      gate_r <= gate_nxt;
    end
  end

  assign gate_o  = gate_r;
  assign short_o = (st_r == CH_SHUT) | (st_r == CH_RETRY);
  assign open_o  = (st_r == CH_OFF_CHK) & ~drain_high_i;
endmodule
`default_nettype wire

/* rtl/lsd_supervisor.sv */
// Four-channel low-side predriver control and fault supervisor top level
// Overview of operation
// - Gate on when parallel or serial asks
// - Parallel inputs act directly, no strobes needed
// - Parallel low-then-high clears shorted-load shutdown
// - Sixty microsecond mask after each turn-on
// - Drain high through deglitch flags short
// - Retry variant drives low-duty pulse train
// - Shutdown fault holds until off-then-on
// - Retry variant clears fault when gone
// - One fault bit per channel, four
// - Open-load checked off only, after mask
// - Drain low after off-mask flags open
// - Over-battery holds all gates off
// - Over-battery reported on flag only
// - Battery fault suppresses load fault reporting
// - Vanished battery fault not captured
// - Chip-select fall clears flag if clean
// - Under-battery holds all gates off
// - Under-battery reported on flag only
// - Reference select picks internal or external
// - Chip-select fall latches channel faults
// - Chip-select rise loads control, re-arms faults
// - Deglitch interval nominally eight microseconds
// - Retry every ten ms, 68 us pulse
`default_nettype none
module lsd_supervisor
  import lsd_pkg::*;
(
  // Clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_i,
  // Variant straps
  input  wire logic                     retry_mode_i,
  input  wire logic                     uvlo_enable_i,
  // Host parallel and serial side
  input  wire logic [lsd_pkg::NCH-1:0]  parallel_channel_in_i,
  input  wire logic                     cs_n_i,
  input  wire logic [lsd_pkg::NCH-1:0]  shifted_ctrl_i,
  // Analog comparator results
  input  wire logic [lsd_pkg::NCH-1:0]  drain_above_int_ref_i,
  input  wire logic [lsd_pkg::NCH-1:0]  drain_above_ext_ref_i,
  input  wire logic                     reference_select_i,
  input  wire logic                     over_bat_i,
  input  wire logic                     under_bat_i,
  // Outputs
  output logic      [lsd_pkg::NCH-1:0]  gate_drive_out_o,
  output logic      [lsd_pkg::NCH-1:0]  fault_word_o,
  output logic                          fault_flag_n_o,
  output logic                          fault_flag_n_oe_o
);
  import lsd_pkg::*;

  // Synchronised pins
  logic [NCH-1:0] par_s;
  logic [NCH-1:0] dint_s;
  logic [NCH-1:0] dext_s;
  logic [4:0]     misc_s;
  logic           retry_s;
  sense_s         sense;
  serial_evt_s    sev;

  lsd_sync #(.W(NCH)) u_sync_par (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (parallel_channel_in_i),
    .q_o        (par_s)
  );
  lsd_sync #(.W(NCH)) u_sync_dint (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (drain_above_int_ref_i),
    .q_o        (dint_s)
  );
  lsd_sync #(.W(NCH)) u_sync_dext (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (drain_above_ext_ref_i),
    .q_o        (dext_s)
  );
  lsd_sync #(.W(5)) u_sync_misc (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    // Select taken active high so the flops' reset value matches the idle pin
    .d_i        ({~cs_n_i, over_bat_i, under_bat_i, reference_select_i, uvlo_enable_i}),
    .q_o        (misc_s)
  );
  // Variant strap is a pin too, so it gets the same two flops
  lsd_sync #(.W(1)) u_sync_mode (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .d_i        (retry_mode_i),
    .q_o        (retry_s)
  );

  // Chip-select edge detect and serial control snapshot
  logic           cs_prev_r;
  logic           cs_prev_nxt;
  logic [NCH-1:0] ctrl_r;
  logic [NCH-1:0] ctrl_nxt;

  always_comb begin
    cs_prev_nxt      = misc_s[4];
    // No false edge after reset, so no stray control load
    sev.cs_fall      = ~cs_prev_r & misc_s[4];
    sev.cs_rise      = cs_prev_r & ~misc_s[4];
    sev.shifted_ctrl = shifted_ctrl_i;
    ctrl_nxt         = ctrl_r;
    if (sev.cs_rise) ctrl_nxt = sev.shifted_ctrl;
  end

  // Reference choice; comparator bank of four, one per channel, per reference
  always_comb begin
    sense.over_bat   = misc_s[3];
    sense.under_bat  = misc_s[2] & misc_s[0];
    sense.drain_high = misc_s[1] ? dext_s : dint_s;
  end

  // Per-channel supervision
  logic [NCH-1:0] short_v;
  logic [NCH-1:0] open_v;
  logic [NCH-1:0] gate_v;
  logic [NCH-1:0] cmd_on;
  logic           bat_fault;

  assign bat_fault = sense.over_bat | sense.under_bat;
  // Parallel input ORed straight in, no strobe needed
  assign cmd_on = par_s | ctrl_r;

  // Timers count core clock cycles, parameters in the package
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    lsd_channel u_ch (
      .core_clk_i   (core_clk_i),
      .rst_i        (rst_i),
      .cmd_on_i     (cmd_on[g]),
      .bat_fault_i  (bat_fault),
      .retry_mode_i (retry_s),
      .drain_high_i (sense.drain_high[g]),
      .gate_o       (gate_v[g]),
      .short_o      (short_v[g]),
      .open_o       (open_v[g])
    );
  end

  // Fault capture, flag and serial word
  logic [NCH-1:0] load_fault;
  logic [NCH-1:0] word_r;
  logic [NCH-1:0] word_nxt;
  logic           flag_r;
  logic           flag_nxt;
  logic           any_fault;

  // Load faults hidden while battery faulted
  assign load_fault = bat_fault ? '0 : (short_v | open_v);
  assign any_fault  = (|load_fault) | bat_fault;

  always_comb begin
    word_nxt = word_r;
    flag_nxt = flag_r;
    // Battery faults never enter the word; only live faults captured
    if (sev.cs_fall) word_nxt = load_fault;
    else if (sev.cs_rise) word_nxt = FAULT_RST;
    // Set wins over clear, so a live fault keeps the flag
    if (any_fault) flag_nxt = 1'b1;
    else if (sev.cs_fall) flag_nxt = 1'b0;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cs_prev_r <= 1'b0;
      ctrl_r    <= CTRL_RST;
      word_r    <= FAULT_RST;
      flag_r    <= 1'b0;
    end else begin
      cs_prev_r <= cs_prev_nxt;
      ctrl_r    <= ctrl_nxt;
      word_r    <= word_nxt;
      flag_r    <= flag_nxt;
    end
  end

  // Open-drain flag: drive low from any fault until a clean select fall
  assign gate_drive_out_o  = gate_v;
  assign fault_word_o      = word_r;
  assign fault_flag_n_o    = 1'b0;
  assign fault_flag_n_oe_o = flag_r;
endmodule
`default_nettype wire

/* dv/lsd_fet_model.sv */
// Power switch and load model feeding the drain comparators
`default_nettype none
module lsd_fet_model (
  // Gate drive and load faults per channel
  input  wire logic [3:0] gate_i,
  input  wire logic [3:0] short_i,
  input  wire logic [3:0] open_i,
  input  wire logic       ext_sel_i,
  // Comparator results
  output logic      [3:0] above_int_o,
  output logic      [3:0] above_ext_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] above;
  // Short keeps drain high; an off drain is pulled up unless open
  assign above = short_i | (~gate_i & ~open_i);
  // Unselected comparator disagrees, so a wrong select shows as faults
  assign above_int_o = ext_sel_i ? ~above : above;
  assign above_ext_o = ext_sel_i ? above : ~above;
endmodule
`default_nettype wire

/* dv/lsd_supervisor_asserts.sv */
// Port-level assertions for the predriver fault supervisor
`default_nettype none
module lsd_sup_chk (
  // Clock and reset
  input wire logic       core_clk_i,
  input wire logic       rst_i,
  // Inputs
  input wire logic       uvlo_enable_i,
  input wire logic [3:0] parallel_channel_in_i,
  input wire logic       cs_n_i,
  input wire logic       over_bat_i,
  input wire logic       under_bat_i,
  // Outputs
  input wire logic [3:0] gate_drive_out_o,
  input wire logic [3:0] fault_word_o,
  input wire logic       fault_flag_n_oe_o
);
  import lsd_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic        bat;
  logic        quiet;
  logic [15:0] on_cnt_r;
  logic [15:0] on_cnt_nxt;
  // Any lockout; channel 0 commanded with no lockout
  assign bat = over_bat_i || (uvlo_enable_i && under_bat_i);
  assign quiet = parallel_channel_in_i[0] && !bat;
  // On time of channel 0, saturating so it never wraps
  always_comb begin
    on_cnt_nxt = 16'h0000;
    if (gate_drive_out_o[0]) begin
      on_cnt_nxt = (&on_cnt_r) ? on_cnt_r : on_cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge core_clk_i) begin
    on_cnt_r <= rst_i ? 16'h0000 : on_cnt_nxt;
  end
  over_off_a: assert property (over_bat_i [*4] |-> gate_drive_out_o == 4'h0)
    else $error("gate on in over-battery");
  under_off_a: assert property ((uvlo_enable_i && under_bat_i) [*4] |-> !(|gate_drive_out_o))
    else $error("gate on in under-battery");
  over_flag_a: assert property (over_bat_i [*4] |-> fault_flag_n_oe_o)
    else $error("flag idle in over-battery");
  bat_word_a: assert property (bat [*6] |-> $stable(fault_word_o) || fault_word_o == 4'h0)
    else $error("load fault captured in lockout");
  par_on_a: assert property ($rose(parallel_channel_in_i[0]) && !bat
    ##1 quiet [*3] |=> gate_drive_out_o[0])
    else $error("parallel input missed gate");
  short_time_a: assert property (quiet [*5] ##1 $fell(gate_drive_out_o[0])
    |-> on_cnt_r >= MASK_CYC + DEGLITCH_CYC - 2)
    else $error("short declared too early");
  flag_clear_a: assert property ($fell(fault_flag_n_oe_o)
    |-> $past(cs_n_i, 6) && !$past(cs_n_i, 2))
    else $error("flag cleared without select fall");
  word_edge_a: assert property (!$stable(fault_word_o) |-> cs_n_i != $past(cs_n_i, 7))
    else $error("fault word moved off select edge");
  // Main scenarios reached
  cover property ($fell(gate_drive_out_o[0]) && quiet);
  cover property ($rose(fault_flag_n_oe_o));
  cover property (fault_word_o != 4'h0);
  cover property ($rose(gate_drive_out_o[0]) && fault_flag_n_oe_o);
endmodule
bind lsd_supervisor lsd_sup_chk u_chk (.*);
`default_nettype wire

/* dv/tb_lowside_predriver_fault_supervisor.sv */
// Self-checking bench for the predriver fault supervisor
`default_nettype none
module tb_lowside_predriver_fault_supervisor;
  timeunit 1ns;
  timeprecision 1ns;
  import lsd_pkg::*;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       cs_n = 1'b1;
  logic       rsel = 1'b0;
  logic       ob = 1'b0;
  logic       ub = 1'b0;
  logic       rmode = 1'b0;
  logic       oe;
  logic       fdat;
  logic [3:0] par = 4'h0;
  logic [3:0] sctl = 4'h0;
  logic [3:0] shrt = 4'h0;
  logic [3:0] opn = 4'h0;
  logic [3:0] gate, word, d_int, d_ext, fl;
  int         fails = 0;
  int         total_checks = 0;
  int         cycles = 0;
  // Flag pin pulled up; reads as fault only when driven low
  assign fl = {3'h0, oe & ~fdat};
  // Variant strap from the bench, lockout strap on
  lsd_supervisor DUT (.core_clk_i(clk), .rst_i(rst), .retry_mode_i(rmode),
    .uvlo_enable_i(1'b1), .parallel_channel_in_i(par), .cs_n_i(cs_n),
    .shifted_ctrl_i(sctl), .drain_above_int_ref_i(d_int), .drain_above_ext_ref_i(d_ext),
    .reference_select_i(rsel), .over_bat_i(ob), .under_bat_i(ub), .gate_drive_out_o(gate),
    .fault_word_o(word), .fault_flag_n_o(fdat), .fault_flag_n_oe_o(oe));
  lsd_fet_model fets (.gate_i(gate), .short_i(shrt), .open_i(opn), .ext_sel_i(rsel),
    .above_int_o(d_int), .above_ext_o(d_ext));
  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  // Hang guard, well past the longest run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Inputs move only at falling edges
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Hold select long enough for the synchroniser
  task automatic cs(input logic v);
    cs_n = v;
    cyc(8);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Swapping reference glitches the sense, so flush with a select cycle
  task automatic set_ref(input logic v);
    rsel = v;
    cyc(8);
    cs(1'b0);
    cs(1'b1);
  endtask
  task automatic t_on();
    par = 4'h1;
    cyc(4);
    chk(gate, 4'h1);
    sctl = 4'h2;
    cs(1'b0);
    cs(1'b1);
    chk(gate, 4'h3);
    sctl = 4'h0;
    par = 4'h0;
    cs(1'b0);
    cs(1'b1);
    chk(gate, 4'h0);
  endtask
  // Shorted load, shutdown variant
  task automatic t_short();
    shrt = 4'h1;
    par = 4'h1;
    cyc(MASK_CYC + 100);
    chk(gate, 4'h1);
    cyc(DEGLITCH_CYC);
    chk(gate, 4'h0);
    chk(fl, 4'h1);
    shrt = 4'h0;
    cyc(200);
    chk(gate, 4'h0);
    cs(1'b0);
    chk(word, 4'h1);
    chk(fl, 4'h1);
    cs(1'b1);
    chk(word, 4'h0);
    par = 4'h0;
    cyc(8);
    par = 4'h1;
    cyc(8);
    chk(gate, 4'h1);
    par = 4'h0;
    cs(1'b0);
    chk(fl, 4'h0);
    cs(1'b1);
  endtask
  // Open load, judged only after the off mask
  task automatic t_open();
    par = 4'h4;
    cyc(8);
    opn = 4'h4;
    cyc(20);
    par = 4'h0;
    cyc(MASK_CYC - 100);
    chk(fl, 4'h0);
    cyc(200);
    chk(fl, 4'h1);
    cs(1'b0);
    chk(word, 4'h4);
    opn = 4'h0;
    cs(1'b1);
    cs(1'b0);
    chk(word, 4'h0);
    chk(fl, 4'h0);
    cs(1'b1);
  endtask
  // Over- then under-battery lockout
  task automatic t_bat();
    for (int k = 0; k < 2; k++) begin
      par = 4'h2;
      cyc(8);
      ob = (k == 0);
      ub = (k == 1);
      cyc(4);
      chk(gate, 4'h0);
      opn = 4'h8;
      cyc(MASK_CYC + 100);
      cs(1'b0);
      chk(word, 4'h0);
      chk(fl, 4'h1);
      opn = 4'h0;
      cyc(4);
      ob = 1'b0;
      ub = 1'b0;
      cyc(8);
      chk(gate, 4'h2);
      cs(1'b1);
      cs(1'b0);
      chk(word, 4'h0);
      chk(fl, 4'h0);
      par = 4'h0;
      cs(1'b1);
    end
  endtask
  // Shorted load, retry variant: first pulse, then recovery at its end
  task automatic t_retry();
    rmode = 1'b1;
    shrt = 4'h1;
    par = 4'h1;
    cyc(MASK_CYC + DEGLITCH_CYC + 3);
    chk(gate, 4'h0);
    cyc(1);
    chk(gate, 4'h1);
    chk(fl, 4'h1);
    cs(1'b0);
    chk(word, 4'h1);
    shrt = 4'h0;
    cs(1'b1);
    cyc(RETRY_PW_CYC);
    chk(gate, 4'h1);
    cs(1'b0);
    chk(word, 4'h0);
    chk(fl, 4'h0);
    cs(1'b1);
    par = 4'h0;
    rmode = 1'b0;
    cyc(8);
  endtask
  initial begin
    cyc(8);
    rst = 1'b0;
    cyc(4);
    chk(gate, 4'h0);
    chk(fl, 4'h0);
    set_ref(1'b0);
    t_on();
    t_short();
    set_ref(1'b1);
    t_open();
    t_bat();
    t_retry();
    wrap_up();
  end
endmodule
`default_nettype wire
